// [common/cbbce_pkg.sv]
package cbbce_pkg;
  // opcode fields
  localparam logic [7:0] OP_BR_CARRY_SET = 8'he2;
  localparam logic [7:0] OP_BR_NEG_SET = 8'he6;
  localparam logic [7:0] OP_BR_CARRY_CLR = 8'he3;
  localparam logic [3:0] OP_BIT_CLR = 4'h9;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int NIB_LO = 12;
  localparam int BIT_HI = 11;
  localparam int BIT_LO = 9;
  localparam int ACC_POS = 8;
  localparam int ADR_HI = 7;
  localparam int OFS_HI = 7;
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [BANK_W-1:0] COMMON_BANK = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  typedef enum logic [0:0] {CBBCE_EXEC, CBBCE_NOP} cbbce_state_t;
endpackage : cbbce_pkg

// [hw/cbbce_exec.sv]
// What this block does
// - upper byte e2 branches only when carry is one, else next instruction.
// - upper byte e6 branches only when negative is one, else next instruction.
// - upper byte e3 branches only when carry is zero, else next instruction.
// - taken target is branch address plus two plus twice signed offset.
// - offset is eight-bit two's complement, minus 128 to plus 127.
// - not taken is one cycle; taken adds one no-operation cycle.
// - upper nibble 9 clears bit b of register f, read-modify-write, flags kept.
// - access bit zero uses common bank; one uses bank select register.
`timescale 1ns/100ps
`default_nettype none
module cbbce_exec (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // instruction from fetch
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [cbbce_pkg::PC_W-1:0] i_instr_pc,
  // status flags
  input wire logic i_flag_carry,
  input wire logic i_flag_negative,
  // bank select and register file read data
  input wire logic [cbbce_pkg::BANK_W-1:0] i_bank_select_reg,
  input wire logic [7:0] i_rf_rdata,
  // fetch control
  output logic o_busy,
  output logic o_pc_load,
  output logic [cbbce_pkg::PC_W-1:0] o_pc_value,
  output logic o_flush,
  // register file access
  output logic [cbbce_pkg::BANK_W-1:0] o_rf_bank,
  output logic [7:0] o_rf_addr,
  output logic o_rf_we,
  output logic [7:0] o_rf_wdata,
  output logic o_flags_we
);
  cbbce_pkg::cbbce_state_t state_ff;
  logic [7:0] opc;
  logic is_brc, is_brn, is_brnc, is_clr, take, accept;
  logic [cbbce_pkg::PC_W-1:0] target;
  cbbce_pkg::cbbce_state_t nxt_state;
  // bank and address of this access, and of the write still in flight
  logic [cbbce_pkg::BANK_W+7:0] rf_key;
  logic [cbbce_pkg::BANK_W+7:0] wr_key_ff;
  // read data with the pending write folded in
  logic [7:0] rf_src;
  // step past the taken branch, kept for the backward-range check
  logic [cbbce_pkg::PC_W-1:0] pc_next_ff;
  logic [cbbce_pkg::PC_W-1:0] back_dist;

  function automatic logic [cbbce_pkg::PC_W-1:0] br_target(
    input logic [cbbce_pkg::PC_W-1:0] pc, input logic [7:0] ofs);
    logic [cbbce_pkg::PC_W-1:0] sx;
    sx = {{(cbbce_pkg::PC_W-8){ofs[cbbce_pkg::OFS_HI]}}, ofs};
    br_target = pc + cbbce_pkg::PC_STEP + {sx[cbbce_pkg::PC_W-2:0], 1'b0};
  endfunction

  assign accept = i_instr_valid && (state_ff == cbbce_pkg::CBBCE_EXEC);
  assign opc = i_instr[cbbce_pkg::OPC_HI:cbbce_pkg::OPC_LO];
  assign is_brc = opc == cbbce_pkg::OP_BR_CARRY_SET;
  assign is_brn = opc == cbbce_pkg::OP_BR_NEG_SET;
  assign is_brnc = opc == cbbce_pkg::OP_BR_CARRY_CLR;
  assign is_clr = i_instr[cbbce_pkg::OPC_HI:cbbce_pkg::NIB_LO] == cbbce_pkg::OP_BIT_CLR;
  assign take = accept && ((is_brc && i_flag_carry)
    || (is_brn && i_flag_negative)
    || (is_brnc && !i_flag_carry));
  assign target = br_target(i_instr_pc, i_instr[cbbce_pkg::OFS_HI:0]);
  assign o_busy = state_ff == cbbce_pkg::CBBCE_NOP;
  assign o_flags_we = 1'b0;

  // extra no-operation cycle after a taken branch
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cbbce_pkg::CBBCE_EXEC: begin
        if (take) begin
          nxt_state = cbbce_pkg::CBBCE_NOP;
        end
      end
      cbbce_pkg::CBBCE_NOP: begin
        // the slot does nothing and always ends after one cycle
        nxt_state = cbbce_pkg::CBBCE_EXEC;
      end
      default: begin
        nxt_state = cbbce_pkg::CBBCE_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_ff <= cbbce_pkg::CBBCE_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pc load at end of the branch cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pc_load <= 1'b0;
      o_flush <= 1'b0;
      o_pc_value <= cbbce_pkg::PC_RST;
    end else begin
      o_pc_load <= take;
      o_flush <= take;
      if (take) begin
        o_pc_value <= target;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pc_next_ff <= cbbce_pkg::PC_RST;
    end else if (take) begin
      pc_next_ff <= i_instr_pc + cbbce_pkg::PC_STEP;
    end
  end

  // distance that a backward branch moved below the next instruction
  assign back_dist = pc_next_ff - o_pc_value;

  // bit clear: address combinational, write registered
  always_comb begin
    o_rf_addr = i_instr[cbbce_pkg::ADR_HI:0];
    if (i_instr[cbbce_pkg::ACC_POS]) begin
      o_rf_bank = i_bank_select_reg;
    end else begin
      o_rf_bank = cbbce_pkg::COMMON_BANK;
    end
  end

  // a clear right after a clear of the same register must see the first
  // result: the register file only takes that write at the end of this cycle
  assign rf_key = {o_rf_bank, o_rf_addr};

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_key_ff <= '0;
    end else if (accept && is_clr) begin
      wr_key_ff <= rf_key;
    end
  end

  always_comb begin
    if (o_rf_we && (wr_key_ff == rf_key)) begin
      rf_src = o_rf_wdata;
    end else begin
      rf_src = i_rf_rdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rf_we <= 1'b0;
      o_rf_wdata <= 8'h00;
    end else begin
      o_rf_we <= accept && is_clr;
      if (accept && is_clr) begin
        o_rf_wdata <= rf_src & ~(8'h01 << i_instr[cbbce_pkg::BIT_HI:cbbce_pkg::BIT_LO]);
      end
    end
  end

  // write address must be held by the register file from the read cycle
  sequence s_branch_cycle;
    o_pc_load && o_flush && o_busy;
  endsequence

  sequence s_nop_done;
    !o_busy && !o_pc_load;
  endsequence

  a_taken_two_cycles: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take |=> s_branch_cycle ##1 s_nop_done) else $error("taken branch timing wrong");
  a_nottaken_one: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && (is_brc || is_brnc || is_brn) && !take |=> !o_pc_load && !o_busy)
    else $error("untaken branch stalled");
  a_carry_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && is_brc && i_flag_carry |=> o_pc_load) else $error("carry branch missed");
  a_neg_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && is_brn && i_flag_negative |=> o_pc_load) else $error("negative branch missed");
  a_carry_clr: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && is_brnc |=> o_pc_load == !$past(i_flag_carry)) else $error("carry clear wrong");
  a_target_calc: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take |=> o_pc_value == $past(i_instr_pc) + cbbce_pkg::PC_STEP
      + {{(cbbce_pkg::PC_W-9){$past(i_instr[7])}}, $past(i_instr[7:0]), 1'b0})
    else $error("branch target wrong");
  a_offset_sign: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take && i_instr[cbbce_pkg::OFS_HI] |=> back_dist != '0
      && back_dist[cbbce_pkg::PC_W-1:cbbce_pkg::OFS_HI+2] == '0)
    else $error("negative offset went forward");
  a_bit_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && is_clr |=> o_rf_we && !o_rf_wdata[$past(i_instr[11:9])]
      && (o_rf_wdata | (8'h01 << $past(i_instr[11:9]))) == ($past(rf_src)
      | (8'h01 << $past(i_instr[11:9])))) else $error("bit clear wrong");
  a_bank_pick: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_instr[8] |-> o_rf_bank == cbbce_pkg::COMMON_BANK) else $error("bank wrong");
  a_addr_field: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_rf_addr == i_instr[7:0]) else $error("address field wrong");
  a_flags_kept: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    take |=> !o_flags_we ##1 !o_flags_we) else $error("flags written");
  a_bank_select: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_instr[cbbce_pkg::ACC_POS] |-> o_rf_bank == i_bank_select_reg)
    else $error("selected bank wrong");
  a_busy_refuse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_busy |=> !o_rf_we && !o_pc_load) else $error("work done in nop slot");
  a_flush_pair: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_flush == o_pc_load) else $error("flush without load");
  a_load_single: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_pc_load |=> !o_pc_load) else $error("load longer than a pulse");
  a_other_nobranch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && !(is_brc || is_brn || is_brnc) |=> !o_pc_load)
    else $error("branch on other opcode");
  a_forward_data: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    accept && is_clr && o_rf_we && (wr_key_ff == rf_key)
      |=> (o_rf_wdata & ~$past(o_rf_wdata)) == 8'h00)
    else $error("back to back clear lost");
  a_reset_quiet: assert property (@(posedge i_clk_sys)
    i_sys_rst |=> !o_pc_load && !o_rf_we && !o_busy) else $error("activity after reset");
endmodule // cbbce_exec
`default_nettype wire

// [verification/cbbce_rf_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cbbce_rf_model (
  // clock
  input wire logic i_clk_sys,
  // access from the block
  input wire logic [3:0] i_bank,
  input wire logic [7:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  // read data
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:4095];
  logic [11:0] adr_ff;
  initial for (int k = 0; k < 4096; k++) mem[k] = k[7:0] ^ 8'h5a;
  assign o_rdata = mem[{i_bank, i_addr}];
  // write lands on the address latched in the issue cycle
  always @(posedge i_clk_sys) begin
    adr_ff <= {i_bank, i_addr};
    if (i_we) mem[adr_ff] <= i_wdata;
  end
endmodule // cbbce_rf_model
`default_nettype wire

// [verification/tb_cond_branch_bit_clear_exec.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_cond_branch_bit_clear_exec;
  logic clk = 0, rst = 1, vld = 0, cy = 0, ng = 0, t, busy, pld, fl, we, fwe;
  logic [15:0] ins = 16'h0000, lf = 16'hdc95;
  logic [20:0] pc = 21'h000000, pv;
  logic [3:0] bank_select_reg = 4'h0, bk, rb;
  logic [7:0] rd, ew, ra, wd, pw = 8'h00;
  logic pcl = 0;
  logic [11:0] pk = 12'h000;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  cbbce_exec dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(ins),
    .i_instr_pc(pc), .i_flag_carry(cy), .i_flag_negative(ng), .i_bank_select_reg(bank_select_reg),
    .i_rf_rdata(rd), .o_busy(busy), .o_pc_load(pld), .o_pc_value(pv), .o_flush(fl),
    .o_rf_bank(rb), .o_rf_addr(ra), .o_rf_we(we), .o_rf_wdata(wd), .o_flags_we(fwe));
  cbbce_rf_model mdl (.i_clk_sys(clk), .i_bank(rb), .i_addr(ra), .i_we(we), .i_wdata(wd),
    .o_rdata(rd));
  function logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input string nm, input logic [20:0] s, input logic [20:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 400; i++) begin
      lf = nx(lf);
      bank_select_reg = lf[3:0];
      cy = lf[4];
      ng = lf[5];
      pc = {4'h0, nx(lf), 1'b0};
      case (lf[7:6])
        2'h0: ins = {cbbce_pkg::OP_BR_CARRY_SET, lf[15:8]};
        2'h1: ins = {cbbce_pkg::OP_BR_NEG_SET, lf[15:8]};
        2'h2: ins = {cbbce_pkg::OP_BR_CARRY_CLR, lf[15:8]};
        default: ins = {cbbce_pkg::OP_BIT_CLR, lf[15:4]};
      endcase
      // extreme offsets first
      if (i < 2 && lf[7:6] != 2'h3) ins[7:0] = i ? 8'h7f : 8'h80;
      // back to back clear of the same register
      if (i % 40 == 5 && pcl) begin
        ins = {4'h9, lf[11:9], |pk[11:8], pk[7:0]};
        bank_select_reg = pk[11:8];
      end
      t = (ins[15:8] == 8'he2 && cy) || (ins[15:8] == 8'he6 && ng) || (ins[15:8] == 8'he3 && !cy);
      bk = ins[8] ? bank_select_reg : 4'h0;
      ew = ((pcl && {bk, ins[7:0]} == pk) ? pw : mdl.mem[{bk, ins[7:0]}]) & ~(8'h01 << ins[11:9]);
      vld = 1;
      #1;
      if (ins[15:12] == 4'h9) chk("rf_bank", rb, bk);
      if (ins[15:12] == 4'h9) chk("rf_addr", ra, ins[7:0]);
      pcl = ins[15:12] == 4'h9;
      pk = {bk, ins[7:0]};
      pw = ew;
      @(negedge clk);
      vld = 0;
      chk("flags_we", fwe, 0);
      if (ins[15:12] == 4'h9) begin
        chk("rf_we", we, 1);
        chk("rf_wdata", wd, ew);
      end else begin
        chk("pc_load", pld, t);
        chk("busy", busy, t);
        chk("flush", fl, t);
        if (t) chk("target", pv, pc + 21'h2 + {{12{ins[7]}}, ins[7:0], 1'b0});
        if (t) begin
          ins = {4'h9, lf[11:0]};
          vld = 1;
          @(negedge clk);
          vld = 0;
          chk("rf_we_busy", we, 0);
          chk("busy_end", busy, 0);
        end
      end
    end
    $display("random test done");
    finish_test;
  end
endmodule // tb_cond_branch_bit_clear_exec
`default_nettype wire
